// file: rtl/fsl_cfg.svh
// Timing constants for the fieldbus card status lamp block.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef FSL_CFG_SVH
`define FSL_CFG_SVH

`define FSL_CLK_HZ          125000000
`define FSL_BLINK_PERIOD_MS 1000
`define FSL_BLINK_ON_MS     500
`define FSL_HALF_CYC        ((`FSL_CLK_HZ / 1000) * `FSL_BLINK_ON_MS)
`define FSL_REP_HALF_MS     200
`define FSL_REP_HALF_CYC    ((`FSL_CLK_HZ / 1000) * `FSL_REP_HALF_MS)
`define FSL_SINGLE_ON_MS    200
`define FSL_SINGLE_FRAME_MS 1200
`define FSL_SINGLE_ON_CYC   ((`FSL_CLK_HZ / 1000) * `FSL_SINGLE_ON_MS)
`define FSL_SINGLE_FRM_CYC  ((`FSL_CLK_HZ / 1000) * `FSL_SINGLE_FRAME_MS)

`endif

// file: rtl/fsl_pkg.sv
// Types shared by the status lamp block.
// Assumes nothing beyond a SystemVerilog compiler.
package fsl_pkg;

	typedef enum logic [1:0] {
		FSL_LINK_SETUP = 2'b00,
		FSL_LINK_UP    = 2'b01,
		FSL_LINK_LOST  = 2'b10
	} fsl_link_type;

	typedef enum logic [1:0] {
		FSL_NODE_OPER    = 2'b00,
		FSL_NODE_PREOP   = 2'b01,
		FSL_NODE_STOPPED = 2'b10
	} fsl_node_type;

	// Error conditions reported by the CAN side and the drive.
	typedef struct packed {
		logic bus_off;
		logic drive_fault;
		logic bad_address;
		logic rx_error;
	} fsl_err_type;

	// Shared blink timing strobes and waves.
	typedef struct packed {
		logic slow_wave;
		logic fast_wave;
		logic single_wave;
		logic single_start;
	} fsl_tick_type;

endpackage

// file: rtl/fsl_blink_gen.sv
// Blink timing generator for the status lamps.
// Assumes one free-running system clock and active-low async reset.
`timescale 1ns/100ps
`include "fsl_cfg.svh"

module fsl_blink_gen
	import fsl_pkg::*;
#(
	parameter int unsigned HALF_CYC       = `FSL_HALF_CYC,
	parameter int unsigned REP_HALF_CYC   = `FSL_REP_HALF_CYC,
	parameter int unsigned SINGLE_ON_CYC  = `FSL_SINGLE_ON_CYC,
	parameter int unsigned SINGLE_FRM_CYC = `FSL_SINGLE_FRM_CYC
) (
	// Clock and reset.
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// Timing outputs.
	output fsl_tick_type      tick
);

	logic [31:0] slow_cnt_reg;
	logic [31:0] fast_cnt_reg;
	logic [31:0] frm_cnt_reg;
	logic        slow_reg;
	logic        fast_reg;

	// End-of-count test shared by the wrapping up-counters.
	function automatic logic at_end(input logic [31:0] cnt,
		input int unsigned lim);
		return cnt == 32'(lim - 1);
	endfunction

	// Slow 50 percent wave: 0.5 s lit, 0.5 s dark.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			slow_cnt_reg <= 32'h0000_0000;
			slow_reg     <= 1'b1;
		end else if (at_end(slow_cnt_reg, HALF_CYC)) begin
			slow_cnt_reg <= 32'h0000_0000;
			slow_reg     <= ~slow_reg;
		end else begin
			slow_cnt_reg <= slow_cnt_reg + 32'h0000_0001;
		end
	end

	// Fast 50 percent wave for the repeated flash.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fast_cnt_reg <= 32'h0000_0000;
			fast_reg     <= 1'b1;
		end else if (at_end(fast_cnt_reg, REP_HALF_CYC)) begin
			fast_cnt_reg <= 32'h0000_0000;
			fast_reg     <= ~fast_reg;
		end else begin
			fast_cnt_reg <= fast_cnt_reg + 32'h0000_0001;
		end
	end

	// Single-flash frame: one short lit pulse at the start of each frame.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			frm_cnt_reg <= 32'h0000_0000;
		end else if (at_end(frm_cnt_reg, SINGLE_FRM_CYC)) begin
			frm_cnt_reg <= 32'h0000_0000;
		end else begin
			frm_cnt_reg <= frm_cnt_reg + 32'h0000_0001;
		end
	end

	// Waves and frame start strobe, packed in field order by one driver.
	assign tick = {slow_reg,
		fast_reg,
		frm_cnt_reg < 32'(SINGLE_ON_CYC),
		frm_cnt_reg == 32'h0000_0000};

endmodule // fsl_blink_gen

// file: rtl/fsl_status_leds.sv
// Lamp driver for the CAN fieldbus extension card status lamps.
// Assumes all status inputs are synchronous to clk_sys.
`timescale 1ns/100ps
`include "fsl_cfg.svh"

module fsl_status_leds
	import fsl_pkg::*;
#(
	parameter int unsigned HALF_CYC       = `FSL_HALF_CYC,
	parameter int unsigned REP_HALF_CYC   = `FSL_REP_HALF_CYC,
	parameter int unsigned SINGLE_ON_CYC  = `FSL_SINGLE_ON_CYC,
	parameter int unsigned SINGLE_FRM_CYC = `FSL_SINGLE_FRM_CYC
) (
	// Clock and reset.
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// Link monitor and node state.
	input  fsl_link_type      link_state,
	input  fsl_node_type      node_state,
	input  wire logic         card_fault,
	// Error conditions; rx_error is a one-cycle event.
	input  fsl_err_type       err_in,
	// Lamps, high is lit.
	output logic              link_lamp,
	output logic              run_lamp,
	output logic              error_lamp
);

	fsl_tick_type tick;
	logic         rx_pend_reg;
	logic         rx_show_reg;
	logic         rx_show_now;
	logic         link_lamp_next;
	logic         run_lamp_next;
	logic         error_lamp_next;

	fsl_blink_gen #(
		.HALF_CYC       (HALF_CYC),
		.REP_HALF_CYC   (REP_HALF_CYC),
		.SINGLE_ON_CYC  (SINGLE_ON_CYC),
		.SINGLE_FRM_CYC (SINGLE_FRM_CYC)
	) u_blink (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.tick    (tick)
	);

	// Receive error waits for the next frame start and is then shown once;
	// one that lands on a frame start is shown in that frame, not kept.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_pend_reg <= 1'b0;
			rx_show_reg <= 1'b0;
		end else if (tick.single_start) begin
			rx_pend_reg <= 1'b0; // Taken into this frame's flash.
			rx_show_reg <= rx_pend_reg | err_in.rx_error;
		end else begin
			rx_pend_reg <= rx_pend_reg | err_in.rx_error;
		end
	end

	// A frame start takes what is pending at once, so the error flash lines
	// up with the frame counter and is never split over two frames.
	always_comb begin
		if (tick.single_start) begin
			rx_show_now = rx_pend_reg | err_in.rx_error;
		end else begin
			rx_show_now = rx_show_reg;
		end
	end

	// Next lamp values from state and timing.
	always_comb begin
		case (link_state)
			FSL_LINK_SETUP: link_lamp_next = 1'b1;
			FSL_LINK_UP:    link_lamp_next = tick.slow_wave;
			default:        link_lamp_next = 1'b0;
		endcase
		if (card_fault) begin
			run_lamp_next = 1'b0;
		end else begin
			case (node_state)
				FSL_NODE_OPER:    run_lamp_next = 1'b1;
				FSL_NODE_PREOP:   run_lamp_next = tick.fast_wave;
				FSL_NODE_STOPPED: run_lamp_next = tick.single_wave;
				default:          run_lamp_next = 1'b0;
			endcase
		end
		if (err_in.bus_off | err_in.drive_fault) begin
			error_lamp_next = 1'b1;
		end else if (err_in.bad_address) begin
			error_lamp_next = tick.fast_wave;
		end else if (rx_show_now) begin
			error_lamp_next = tick.single_wave;
		end else begin
			error_lamp_next = 1'b0;
		end
	end

	// Lamp outputs are registered.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			link_lamp  <= 1'b0;
			run_lamp   <= 1'b0;
			error_lamp <= 1'b0;
		end else begin
			link_lamp  <= link_lamp_next;
			run_lamp   <= run_lamp_next;
			error_lamp <= error_lamp_next;
		end
	end

	property p_link_setup;
		@(posedge clk_sys) disable iff (!rst_b)
		link_state == FSL_LINK_SETUP |=> link_lamp;
	endproperty
	a_link_setup: assert property (p_link_setup)
		else $error("Link lamp not lit during setup.");

	property p_link_blink;
		@(posedge clk_sys) disable iff (!rst_b)
		(link_state == FSL_LINK_UP) ##1 (link_state == FSL_LINK_UP)
			|-> link_lamp == $past(tick.slow_wave);
	endproperty
	a_link_blink: assert property (p_link_blink)
		else $error("Link lamp does not follow the slow wave.");

	property p_link_lost;
		@(posedge clk_sys) disable iff (!rst_b)
		link_state == FSL_LINK_LOST |=> !link_lamp;
	endproperty
	a_link_lost: assert property (p_link_lost)
		else $error("Link lamp lit after link loss.");

	property p_run_oper;
		@(posedge clk_sys) disable iff (!rst_b)
		(node_state == FSL_NODE_OPER && !card_fault) |=> run_lamp;
	endproperty
	a_run_oper: assert property (p_run_oper)
		else $error("Run lamp dark while operational.");

	property p_run_fault;
		@(posedge clk_sys) disable iff (!rst_b)
		card_fault |=> !run_lamp;
	endproperty
	a_run_fault: assert property (p_run_fault)
		else $error("Run lamp lit during card fault.");

	property p_run_preop;
		@(posedge clk_sys) disable iff (!rst_b)
		(node_state == FSL_NODE_PREOP && !card_fault)
			|=> run_lamp == $past(tick.fast_wave);
	endproperty
	a_run_preop: assert property (p_run_preop)
		else $error("Run lamp does not flash in pre-operational.");

	property p_run_stop;
		@(posedge clk_sys) disable iff (!rst_b)
		(node_state == FSL_NODE_STOPPED && !card_fault)
			|=> run_lamp == $past(tick.single_wave);
	endproperty
	a_run_stop: assert property (p_run_stop)
		else $error("Run lamp does not single flash when stopped.");

	property p_err_steady;
		@(posedge clk_sys) disable iff (!rst_b)
		(err_in.bus_off || err_in.drive_fault) |=> error_lamp;
	endproperty
	a_err_steady: assert property (p_err_steady)
		else $error("Error lamp dark on bus-off or drive fault.");

	property p_err_dark;
		@(posedge clk_sys) disable iff (!rst_b)
		(!err_in.bus_off && !err_in.drive_fault && !err_in.bad_address
			&& !rx_show_now) |=> !error_lamp;
	endproperty
	a_err_dark: assert property (p_err_dark)
		else $error("Error lamp lit with no error.");

	property p_err_addr;
		@(posedge clk_sys) disable iff (!rst_b)
		(err_in.bad_address && !err_in.bus_off && !err_in.drive_fault)
			|=> error_lamp == $past(tick.fast_wave);
	endproperty
	a_err_addr: assert property (p_err_addr)
		else $error("Error lamp does not flash on bad address.");

	property p_err_rx;
		@(posedge clk_sys) disable iff (!rst_b)
		(err_in.rx_error && tick.single_start) |=> rx_show_reg;
	endproperty
	a_err_rx: assert property (p_err_rx)
		else $error("Receive error not scheduled for a single flash.");

	property p_err_single;
		@(posedge clk_sys) disable iff (!rst_b)
		(rx_show_now && !err_in.bus_off && !err_in.drive_fault
			&& !err_in.bad_address)
			|=> error_lamp == $past(tick.single_wave);
	endproperty
	a_err_single: assert property (p_err_single)
		else $error("Error lamp does not give the single flash.");

	property p_link_dark;
		@(posedge clk_sys) disable iff (!rst_b)
		(link_state != FSL_LINK_SETUP && link_state != FSL_LINK_UP)
			|=> !link_lamp;
	endproperty
	a_link_dark: assert property (p_link_dark)
		else $error("Link lamp lit with the link neither set up nor up.");

endmodule // fsl_status_leds

// file: testbench/fsl_status_src.sv
// Model of the drive control board and CAN status sources.
// Assumes the bench changes its requests at the falling clock edge.
`timescale 1ns/100ps

module fsl_status_src
	import fsl_pkg::*;
(
	// Clock.
	input  wire logic   clk_sys,
	// Requests from the bench.
	input  fsl_link_type link_req,
	input  fsl_node_type node_req,
	input  wire logic    fault_req,
	input  fsl_err_type  err_req,
	// Status towards the lamp block.
	output fsl_link_type link_state,
	output fsl_node_type node_state,
	output logic         card_fault,
	output fsl_err_type  err_in
);
	// Power up in link setup with no fault so no input is unknown.
	initial begin
		link_state = FSL_LINK_SETUP;
		node_state = FSL_NODE_OPER;
		card_fault = 1'b0;
		err_in     = 4'h0;
	end

	// Status moves on the falling edge, well clear of sampling.
	always @(negedge clk_sys) begin
		link_state <= link_req;
		node_state <= node_req;
		card_fault <= fault_req;
		err_in     <= err_req;
	end
endmodule // fsl_status_src

// file: testbench/fsl_status_leds_tb.sv
// Self-checking bench for the status lamp block.
// Assumes shortened blink counts; the 120-cycle table windows span whole blink periods.
`timescale 1ns/100ps

module fsl_status_leds_tb;
	import fsl_pkg::*;
	typedef struct {
		fsl_link_type l;
		fsl_node_type n;
		logic         f;
		fsl_err_type  e;
		int           ex[6];
	} fsl_row_type;

	logic         clk_sys = 1'b0;
	logic         rst_b   = 1'b0;
	fsl_link_type link_req = FSL_LINK_SETUP;
	fsl_node_type node_req = FSL_NODE_OPER;
	logic         fault_req = 1'b0;
	fsl_err_type  err_req  = 4'h0;
	fsl_link_type link_state;
	fsl_node_type node_state;
	logic         card_fault;
	fsl_err_type  err_in;
	logic         link_lamp, run_lamp, error_lamp;
	int           miscompares = 0;
	int           check_count = 0;
	int           wait_n;
	int           got[6];
	fsl_row_type  rows[5];
	string        nm[6] = '{"link lit", "link toggles", "run lit",
		"run toggles", "error lit", "error toggles"};

	// Clock at 125 MHz.
	always #4 clk_sys = ~clk_sys;

	fsl_status_src SRC (.clk_sys(clk_sys), .link_req(link_req),
		.node_req(node_req), .fault_req(fault_req), .err_req(err_req),
		.link_state(link_state), .node_state(node_state),
		.card_fault(card_fault), .err_in(err_in));

	fsl_status_leds #(.HALF_CYC(10), .REP_HALF_CYC(4), .SINGLE_ON_CYC(3),
		.SINGLE_FRM_CYC(12)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
		.link_state(link_state), .node_state(node_state),
		.card_fault(card_fault), .err_in(err_in), .link_lamp(link_lamp),
		.run_lamp(run_lamp), .error_lamp(error_lamp));

	// Compares one count and reports a mismatch.
	task automatic chk(input string name, input int exp, input int seen);
		check_count++;
		if (exp != seen) begin
			miscompares++;
			$display("[ERR] %s expected %0d seen %0d", name, exp, seen);
		end
	endtask

	// Counts lit cycles and changes of each lamp over n cycles.
	task automatic measure(input int n);
		logic [2:0] prev;
		logic [2:0] cur;
		prev = {link_lamp, run_lamp, error_lamp};
		got = '{0, 0, 0, 0, 0, 0};
		repeat (n) begin
			@(negedge clk_sys);
			cur = {link_lamp, run_lamp, error_lamp};
			for (int k = 0; k < 3; k++) begin
				got[2*k] += (cur[2-k] === 1'b1);
				got[2*k+1] += (cur[2-k] !== prev[2-k]);
			end
			prev = cur;
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic final_report();
		if (miscompares == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence: reset, table of steady cases, then single flashes.
	initial begin
		rows[0] = '{FSL_LINK_SETUP, FSL_NODE_OPER, 1'b0, 4'h0,
			'{120, 0, 120, 0, 0, 0}};
		rows[1] = '{FSL_LINK_UP, FSL_NODE_PREOP, 1'b0, 4'h0,
			'{60, 12, 60, 30, 0, 0}};
		rows[2] = '{FSL_LINK_LOST, FSL_NODE_STOPPED, 1'b0, 4'h2,
			'{0, 0, 30, 20, 60, 30}};
		rows[3] = '{FSL_LINK_UP, FSL_NODE_OPER, 1'b1, 4'h8,
			'{60, 12, 0, 0, 120, 0}};
		rows[4] = '{FSL_LINK_LOST, FSL_NODE_PREOP, 1'b0, 4'h6,
			'{0, 0, 60, 30, 120, 0}};
		repeat (3) @(negedge clk_sys);
		if ({link_lamp, run_lamp, error_lamp} !== 3'h0) begin
			miscompares++;
			$display("[ERR] lamps in reset expected 0 seen %b",
				{link_lamp, run_lamp, error_lamp});
		end
		check_count++;
		@(negedge clk_sys);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			link_req  <= rows[i].l;
			node_req  <= rows[i].n;
			fault_req <= rows[i].f;
			err_req   <= rows[i].e;
			repeat (4) @(negedge clk_sys);
			measure(120);
			for (int k = 0; k < 6; k++)
				chk(nm[k], rows[i].ex[k], got[k]);
		end
		// One receive error gives one short flash, then none.
		err_req <= 4'h1;
		@(negedge clk_sys);
		err_req <= 4'h0;
		measure(30);
		chk(nm[4], 3, got[4]);
		chk(nm[5], 3, got[5]);
		measure(24);
		chk(nm[4], 0, got[4]);
		// A receive error under bus-off leaves the lamp steady.
		err_req <= 4'h9;
		@(negedge clk_sys);
		err_req <= 4'h8;
		repeat (3) @(negedge clk_sys);
		measure(30);
		chk(nm[4], 30, got[4]);
		// A receive error right at a frame start flashes once, not twice.
		err_req  <= 4'h0;
		node_req <= FSL_NODE_STOPPED;
		repeat (4) @(negedge clk_sys);
		wait_n = 0;
		while (run_lamp !== 1'b0 && wait_n < 40) begin
			@(negedge clk_sys);
			wait_n++;
		end
		while (run_lamp !== 1'b1 && wait_n < 40) begin
			@(negedge clk_sys);
			wait_n++;
		end
		check_count++;
		if (wait_n >= 40) begin
			miscompares++;
			$display("[ERR] frame start expected 1 seen %b", run_lamp);
		end
		// The run lamp rose one edge after a frame start; aim at the next.
		repeat (10) @(negedge clk_sys);
		err_req <= 4'h1;
		@(negedge clk_sys);
		err_req <= 4'h0;
		measure(30);
		chk(nm[4], 3, got[4]);
		chk(nm[5], 2, got[5]);
		final_report();
	end
endmodule // fsl_status_leds_tb
